// file: rtl/t0ps_pkg.sv
// Constants, register map and state carrier for the eight-bit timer with shared prescaler.
// Assumes a single 25 MHz pclk domain and APB access with 32-bit data words.

package t0ps_pkg;

  // Register indices; the byte address on APB is four times the index.
  localparam logic [7:0] T0PS_IDX_COUNT = 8'h01;
  localparam logic [7:0] T0PS_IDX_PORTA = 8'h05;
  localparam logic [7:0] T0PS_IDX_INTCTL = 8'h0B;
  localparam logic [7:0] T0PS_IDX_INTCTL_ALT = 8'h8B;
  localparam logic [7:0] T0PS_IDX_OPTION = 8'h81;
  localparam logic [7:0] T0PS_IDX_PADIR = 8'h85;
  localparam logic [7:0] T0PS_IDX_CORE_CTL = 8'hC0;

  // Option register field positions.
  localparam int T0PS_OPT_SRC = 5;
  localparam int T0PS_OPT_EDGE = 4;
  localparam int T0PS_OPT_ASSIGN = 3;
  localparam int T0PS_OPT_RATIO_LSB = 0;

  // Interrupt control field positions.
  localparam int T0PS_IC_GLOBAL = 7;
  localparam int T0PS_IC_PERIPH = 6;
  localparam int T0PS_IC_OVF_EN = 5;
  localparam int T0PS_IC_OVF_FLAG = 2;
  localparam int T0PS_IC_EXT_FLAG = 1;
  localparam int T0PS_IC_PORT_FLAG = 0;

  // Core control register fields: sleep level and watchdog clear strobe.
  localparam int T0PS_CC_SLEEP = 0;
  localparam int T0PS_CC_WDT_CLEAR = 1;

  // Reset values.
  localparam logic [7:0] T0PS_RST_OPTION = 8'hFF;
  localparam logic [7:0] T0PS_RST_INTCTL = 8'h00;
  localparam logic [5:0] T0PS_RST_PADIR = 6'h3F;
  localparam logic [4:0] T0PS_RST_PALATCH = 5'h00;

  // Timing: clock periods per instruction cycle and write stall length.
  localparam int T0PS_PCLK_HZ = 25000000;
  localparam int T0PS_CLKS_PER_INSTR = 4;
  localparam logic [1:0] T0PS_WRITE_STALL = 2'h2;
  localparam int T0PS_PIN_BIT = 4;

  // APB answer group.
  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } t0ps_apb_rsp_t;

  // Whole module state.
  typedef struct packed {
    t0ps_apb_rsp_t rsp;
    logic [1:0] phase;
    logic [1:0] stall;
    logic [7:0] count;
    logic [7:0] psc;
    logic [7:0] option;
    logic [7:0] intctl;
    logic [5:0] padir;
    logic [4:0] palatch;
    logic sleep;
    logic pin_meta;
    logic pin_sync;
    logic pin_prev;
    logic irq;
    logic wdt_tick;
    logic wdt_clear;
    logic [4:0] pa_out;
    logic [4:0] pa_oe;
  } t0ps_state_t;

endpackage

// file: rtl/t0ps_timer.sv
// Eight-bit timer/counter with a prescaler shared with the watchdog, behind an APB slave.
// Assumes inputs synchronous to pclk except the counter pin, which is synchronised here.
//
// Our own choice: the APB register port.

`timescale 1ns/10ps
`default_nettype none

module t0ps_timer #(
  parameter int CLKS_PER_INSTR = t0ps_pkg::T0PS_CLKS_PER_INSTR
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic pready,
  output logic pslverr,
  output logic [31:0] prdata,
  input wire logic soft_reset,
  input wire logic ext_flag_set,
  input wire logic port_change_set,
  input wire logic wdt_base_tick,
  input wire logic [4:0] pa_in,
  output logic [4:0] pa_out,
  output logic [4:0] pa_oe,
  output logic ovf_irq,
  output logic wdt_tick,
  output logic wdt_clear
);

  // The phase counter is two bits wide, so only four clocks per instruction fit.
  initial begin
    if (CLKS_PER_INSTR != 4) begin
      $error("CLKS_PER_INSTR must be 4");
    end
  end

  t0ps_pkg::t0ps_state_t s_q;
  t0ps_pkg::t0ps_state_t s_d;

  // Ratio mask: low bits of the prescaler that must all be one for a tick.
  function automatic logic [7:0] ratio_mask(input logic [2:0] ratio, input logic to_timer);
    logic [8:0] m;
    m = 9'h000;
    if (to_timer) begin
      m = (9'h002 << ratio) - 9'h001;
    end else begin
      m = (9'h001 << ratio) - 9'h001;
    end
    ratio_mask = m[7:0];
  endfunction

  // Read multiplexer over the register map.
  function automatic logic [7:0] read_reg(input t0ps_pkg::t0ps_state_t st,
                                          input logic [7:0] idx,
                                          input logic [4:0] pins);
    read_reg = 8'h00;
    case (idx)
      t0ps_pkg::T0PS_IDX_COUNT: begin
        read_reg = st.count;
      end
      t0ps_pkg::T0PS_IDX_PORTA: begin
        read_reg = {3'h0, pins};
      end
      t0ps_pkg::T0PS_IDX_INTCTL, t0ps_pkg::T0PS_IDX_INTCTL_ALT: begin
        read_reg = st.intctl;
      end
      t0ps_pkg::T0PS_IDX_OPTION: begin
        read_reg = st.option;
      end
      t0ps_pkg::T0PS_IDX_PADIR: begin
        read_reg = {2'h0, st.padir};
      end
      t0ps_pkg::T0PS_IDX_CORE_CTL: begin
        read_reg = {7'h00, st.sleep};
      end
      default: begin
        read_reg = 8'h00;
      end
    endcase
  endfunction

  // Address decode shared by the read and write paths.
  function automatic logic is_mapped(input logic [7:0] idx);
    case (idx)
      t0ps_pkg::T0PS_IDX_COUNT, t0ps_pkg::T0PS_IDX_PORTA, t0ps_pkg::T0PS_IDX_INTCTL,
      t0ps_pkg::T0PS_IDX_INTCTL_ALT, t0ps_pkg::T0PS_IDX_OPTION, t0ps_pkg::T0PS_IDX_PADIR,
      t0ps_pkg::T0PS_IDX_CORE_CTL: begin
        is_mapped = 1'b1;
      end
      default: begin
        is_mapped = 1'b0;
      end
    endcase
  endfunction

  logic [7:0] idx;
  logic aligned;
  logic setup;
  logic wr;
  logic instr_tick;
  logic to_timer;
  logic cnt_src;
  logic pin_edge;
  logic psc_in;
  logic psc_hit;
  logic cnt_tick;
  logic wr_count;
  logic wr_clear_wdt;
  logic ovf;
  logic [7:0] mask;

  // Decode of the current APB request; registers sit one word apart.
  assign idx = paddr[9:2];
  assign aligned = (paddr[1:0] == 2'h0) && (paddr[11:10] == 2'h0);
  assign setup = psel && !penable;
  assign wr = psel && penable && s_q.rsp.pready && pwrite && !s_q.rsp.pslverr;
  assign wr_count = wr && (idx == t0ps_pkg::T0PS_IDX_COUNT);
  assign wr_clear_wdt = wr && (idx == t0ps_pkg::T0PS_IDX_CORE_CTL) &&
                        pwdata[t0ps_pkg::T0PS_CC_WDT_CLEAR];

  // Instruction cycle strobe: one clock in every four of the phase counter.
  assign instr_tick = (s_q.phase == 2'(CLKS_PER_INSTR - 1));

  assign to_timer = !s_q.option[t0ps_pkg::T0PS_OPT_ASSIGN];

  // edge select polarity
  // Inverting both samples turns a falling edge into a rising one, so one detector serves.
  assign pin_edge = (s_q.pin_sync ^ s_q.option[t0ps_pkg::T0PS_OPT_EDGE]) &&
                    !(s_q.pin_prev ^ s_q.option[t0ps_pkg::T0PS_OPT_EDGE]);

  assign cnt_src = s_q.option[t0ps_pkg::T0PS_OPT_SRC] ? pin_edge : instr_tick;

  // sleep stops the timer
  // The prescaler input is the timer source when owned by the timer, else the watchdog base.
  assign psc_in = to_timer ? (cnt_src && !s_q.sleep) : wdt_base_tick;

  assign mask = ratio_mask(s_q.option[2:0], to_timer);
  assign psc_hit = psc_in && ((s_q.psc & mask) == mask);

  assign cnt_tick = !s_q.sleep && (s_q.stall == 2'h0) && (to_timer ? psc_hit : cnt_src);

  assign ovf = cnt_tick && (s_q.count == 8'hFF) && !wr_count;

  // Next-state logic for the whole block.
  always_comb begin
    s_d = s_q;
    s_d.wdt_tick = 1'b0;
    s_d.wdt_clear = 1'b0;

    // APB answer: registered one cycle after setup, so every access has no wait beyond it.
    s_d.rsp.pready = 1'b0;
    s_d.rsp.pslverr = 1'b0;
    if (setup) begin
      s_d.rsp.pready = 1'b1;
      s_d.rsp.pslverr = !(aligned && is_mapped(idx));
      s_d.rsp.prdata = {24'h000000, read_reg(s_q, idx, pa_in)};
      if (!(aligned && is_mapped(idx)) || pwrite) begin
        s_d.rsp.prdata = 32'h00000000;
      end
    end

    // Instruction phase counter runs free, even in sleep, to keep cycle alignment.
    s_d.phase = s_q.phase + 2'h1;

    s_d.pin_meta = pa_in[t0ps_pkg::T0PS_PIN_BIT];
    s_d.pin_sync = s_q.pin_meta;
    s_d.pin_prev = s_q.pin_sync;

    // Stall counter decrements once per instruction cycle.
    if ((s_q.stall != 2'h0) && instr_tick) begin
      s_d.stall = s_q.stall - 2'h1;
    end

    if (psc_in) begin
      s_d.psc = s_q.psc + 8'h01;
    end
    if (!to_timer && psc_hit) begin
      s_d.wdt_tick = 1'b1;
    end

    if (cnt_tick) begin
      s_d.count = s_q.count + 8'h01;
    end

    // Register writes take effect at the access edge only.
    if (wr) begin
      case (idx)
        t0ps_pkg::T0PS_IDX_COUNT: begin
          s_d.count = pwdata[7:0];
          s_d.stall = t0ps_pkg::T0PS_WRITE_STALL;
          if (to_timer) begin
            s_d.psc = 8'h00;
          end
        end
        t0ps_pkg::T0PS_IDX_PORTA: begin
          s_d.palatch = pwdata[4:0];
        end
        t0ps_pkg::T0PS_IDX_INTCTL, t0ps_pkg::T0PS_IDX_INTCTL_ALT: begin
          s_d.intctl = pwdata[7:0];
        end
        t0ps_pkg::T0PS_IDX_OPTION: begin
          s_d.option = pwdata[7:0];
        end
        t0ps_pkg::T0PS_IDX_PADIR: begin
          s_d.padir = pwdata[5:0];
        end
        t0ps_pkg::T0PS_IDX_CORE_CTL: begin
          s_d.sleep = pwdata[t0ps_pkg::T0PS_CC_SLEEP];
        end
        default: begin
          s_d.sleep = s_q.sleep;
        end
      endcase
    end

    if (wr_clear_wdt) begin
      s_d.wdt_clear = 1'b1;
      if (!to_timer) begin
        s_d.psc = 8'h00;
        s_d.wdt_tick = 1'b0;
      end
    end

    // overflow sets the flag
    // A hardware set lands after a software write so an event is never lost.
    if (ovf) begin
      s_d.intctl[t0ps_pkg::T0PS_IC_OVF_FLAG] = 1'b1;
    end
    if (ext_flag_set) begin
      s_d.intctl[t0ps_pkg::T0PS_IC_EXT_FLAG] = 1'b1;
    end
    if (port_change_set) begin
      s_d.intctl[t0ps_pkg::T0PS_IC_PORT_FLAG] = 1'b1;
    end

    if (soft_reset) begin
      s_d.intctl = {t0ps_pkg::T0PS_RST_INTCTL[7:1], s_q.intctl[t0ps_pkg::T0PS_IC_PORT_FLAG]};
      s_d.option = t0ps_pkg::T0PS_RST_OPTION;
      s_d.padir = t0ps_pkg::T0PS_RST_PADIR;
      s_d.sleep = 1'b0;
    end

    s_d.irq = s_d.intctl[t0ps_pkg::T0PS_IC_OVF_FLAG] && s_d.intctl[t0ps_pkg::T0PS_IC_OVF_EN];

    // direction one means input
    // Pin four is open drain: it only ever pulls low.
    s_d.pa_out = s_d.palatch;
    s_d.pa_oe = ~s_d.padir[4:0];
    s_d.pa_out[t0ps_pkg::T0PS_PIN_BIT] = 1'b0;
    s_d.pa_oe[t0ps_pkg::T0PS_PIN_BIT] = !s_d.padir[t0ps_pkg::T0PS_PIN_BIT] &&
                                        !s_d.palatch[t0ps_pkg::T0PS_PIN_BIT];
  end

  // State register; power-on reset clears the port change flag as well.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= '0;
      s_q.option <= t0ps_pkg::T0PS_RST_OPTION;
      s_q.intctl <= t0ps_pkg::T0PS_RST_INTCTL;
      s_q.padir <= t0ps_pkg::T0PS_RST_PADIR;
      s_q.palatch <= t0ps_pkg::T0PS_RST_PALATCH;
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs straight from the state flip-flops.
  assign pready = s_q.rsp.pready;
  assign pslverr = s_q.rsp.pslverr;
  assign prdata = s_q.rsp.prdata;
  assign pa_out = s_q.pa_out;
  assign pa_oe = s_q.pa_oe;
  assign ovf_irq = s_q.irq;
  assign wdt_tick = s_q.wdt_tick;
  assign wdt_clear = s_q.wdt_clear;

endmodule

`default_nettype wire

// file: sim/t0ps_pin_src.sv
// Model of the pulse source on the counter input pin.
// Assumes its tasks are called from one bench process.
`timescale 1ns/10ps
`default_nettype none
module t0ps_pin_src (
  input wire logic pclk,
  output logic pin
);
  // The pin idles low until a task moves it.
  initial pin = 1'b0;
  // hold each level
  // Seven clocks per level clear the synchroniser with margin to spare.
  task automatic level(input logic lv);
    @(posedge pclk);
    pin <= lv;
    repeat (6) @(posedge pclk);
  endtask
  // Whole pulses only, so the pin always ends low.
  task automatic pulses(input int n);
    repeat (n) begin
      level(1'b1);
      level(1'b0);
    end
  endtask
endmodule
`default_nettype wire

// file: sim/t0ps_timer_sva.sv
// Port-level checks for the timer block.
// Assumes one pclk domain and the design top t0ps_timer.
`timescale 1ns/10ps
`default_nettype none
module t0ps_timer_sva (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [31:0] prdata,
  input wire logic soft_reset,
  input wire logic wdt_base_tick,
  input wire logic [4:0] pa_out,
  input wire logic ovf_irq,
  input wire logic wdt_tick,
  input wire logic wdt_clear
);
  // Everything lives in one domain, so clock and reset are set once.
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_ready_setup: assert property (psel && !penable |=> pready)
    else $error("No answer after a setup cycle.");
  a_ready_single: assert property (pready |=> !pready)
    else $error("Ready held past one cycle.");
  a_err_nodata: assert property (pslverr |-> pready && prdata == 32'h0)
    else $error("Refused access returned data.");
  a_read_narrow: assert property (pready |-> prdata[31:8] == 24'h0)
    else $error("Upper read bits not zero.");
  a_open_drain: assert property (pa_out[4] == 1'b0)
    else $error("Counter pin driven high.");
  a_soft_irq: assert property (soft_reset |=> ##1 !ovf_irq)
    else $error("Request survived soft reset.");
  a_wdt_clear: assert property (psel && penable && pready && pwrite
    && paddr == 12'h300 && pwdata[1] |-> ##[0:2] wdt_clear)
    else $error("Watchdog clear pulse missing.");
  a_tick_cause: assert property (wdt_tick |->
    $past(wdt_base_tick, 1) || $past(wdt_base_tick, 2))
    else $error("Watchdog tick without base tick.");
endmodule
bind t0ps_timer t0ps_timer_sva u_sva (.pclk, .presetn, .psel, .penable, .pwrite,
  .paddr, .pwdata, .pready, .pslverr, .prdata, .soft_reset, .wdt_base_tick,
  .pa_out, .ovf_irq, .wdt_tick, .wdt_clear);
`default_nettype wire

// file: sim/t0ps_timer_test.sv
// Self-checking bench for the timer block, driven over APB.
// Assumes the design, its checker and the pin source are compiled first.
`timescale 1ns/10ps
`default_nettype none
module t0ps_timer_test;
  logic pclk, presetn, psel, penable, pwrite, soft_reset, wdt_base_tick;
  logic src_pin, pready, pslverr, ovf_irq, wdt_tick, wdt_clear, e;
  logic ext_set, port_set;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, v, w;
  logic [4:0] pa_in, pa_out, pa_oe;
  logic [3:0] low4;
  int num_errors, compares, ticks, t0;
  // The pin wire is low whenever the open-drain driver pulls it.
  assign pa_in = {src_pin & ~pa_oe[4], low4};
  t0ps_timer DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .pready, .pslverr, .prdata, .soft_reset, .ext_flag_set(ext_set),
    .port_change_set(port_set), .wdt_base_tick, .pa_in, .pa_out, .pa_oe, .ovf_irq,
    .wdt_tick, .wdt_clear);
  t0ps_pin_src src (.pclk(pclk), .pin(src_pin));
  // Free-running 25 MHz clock.
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  // Tally of prescaled watchdog ticks.
  always @(posedge pclk) begin
    if (wdt_tick === 1'b1) ticks <= ticks + 1;
  end
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    compares++;
    if (g !== x) begin
      num_errors++;
      $display("Error %0t: got %h, expected %h", $time, g, x);
    end
  endtask
  // One APB transfer; ready and read data are taken at the rising edge that samples ready.
  task automatic xf(input logic wr_en, input logic [7:0] i, input logic [7:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr_en;
    paddr <= {2'h0, i, 2'h0};
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    // The answer is taken at the sampling edge, and only then is the request released.
    v = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    chk(32'(n), 32'h1);
  endtask
  task automatic rd(input logic [7:0] i, input logic [31:0] x);
    xf(1'b0, i, 8'h00);
    chk(v, x);
  endtask
  task automatic summarize();
    if (num_errors == 0 && compares > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // A hung run counts as a failure; the tests need about 1850 cycles.
  initial begin
    repeat (20000) @(posedge pclk);
    num_errors++;
    summarize();
  end
  initial begin
    {presetn, psel, penable, pwrite, soft_reset, wdt_base_tick} = 6'h00;
    paddr = 12'h000;
    pwdata = 32'h0;
    low4 = 4'h0;
    {ext_set, port_set} = 2'h0;
    num_errors = 0;
    compares = 0;
    ticks = 0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    rd(8'h81, 32'hFF);
    rd(8'h0B, 32'h00);
    rd(8'h85, 32'h3F);
    xf(1'b0, 8'hFF, 8'h00);
    chk({31'h0, e}, 32'h1);
    xf(1'b1, 8'h81, 8'h08);
    xf(1'b1, 8'h01, 8'h10);
    repeat (37) @(posedge pclk);
    xf(1'b0, 8'h01, 8'h00);
    w = v - 32'h10;
    chk({31'h0, w == 32'h7 || w == 32'h8}, 32'h1);
    w = v;
    repeat (37) @(posedge pclk);
    xf(1'b0, 8'h01, 8'h00);
    chk({24'h0, v[7:0] - w[7:0]}, 32'hA);
    for (int r = 0; r < 3; r++) begin
      xf(1'b1, 8'h81, 8'(r));
      xf(1'b0, 8'h01, 8'h00);
      w = v;
      repeat ((32 << r) - 3) @(posedge pclk);
      xf(1'b0, 8'h01, 8'h00);
      chk({24'h0, v[7:0] - w[7:0]}, 32'h4);
    end
    // count write clears the prescaler; at 1:8 the next tick is eight instruction cycles (32 clocks) away.
    xf(1'b1, 8'h01, 8'h00);
    repeat (20) @(posedge pclk);
    rd(8'h01, 32'h00);
    repeat (10) @(posedge pclk);
    rd(8'h01, 32'h01);
    // safe move to the watchdog: clear, reload count, then reassign.
    xf(1'b1, 8'hC0, 8'h02);
    xf(1'b1, 8'h01, 8'h00);
    xf(1'b1, 8'h81, 8'h08);
    xf(1'b1, 8'h0B, 8'h20);
    xf(1'b1, 8'h01, 8'hFE);
    repeat (30) @(posedge pclk);
    rd(8'h0B, 32'h24);
    chk({31'h0, ovf_irq}, 32'h1);
    xf(1'b1, 8'h0B, 8'h00);
    @(posedge pclk);
    chk({31'h0, ovf_irq}, 32'h0);
    repeat (1100) @(posedge pclk);
    rd(8'h0B, 32'h04);
    chk({31'h0, ovf_irq}, 32'h0);
    xf(1'b1, 8'hC0, 8'h01);
    xf(1'b0, 8'h01, 8'h00);
    w = v;
    repeat (37) @(posedge pclk);
    rd(8'h01, w);
    xf(1'b1, 8'hC0, 8'h00);
    for (int r = 0; r < 2; r++) begin
      xf(1'b1, 8'h81, 8'(8 + r));
      xf(1'b1, 8'hC0, 8'h02);
      t0 = ticks;
      repeat (8) begin
        @(posedge pclk);
        wdt_base_tick <= 1'b1;
        @(posedge pclk);
        wdt_base_tick <= 1'b0;
        repeat (3) @(posedge pclk);
      end
      chk(32'(ticks - t0), 32'(8 >> r));
    end
    xf(1'b1, 8'h81, 8'h28);
    xf(1'b1, 8'h01, 8'h00);
    repeat (12) @(posedge pclk);
    src.pulses(5);
    rd(8'h01, 32'h05);
    xf(1'b1, 8'h81, 8'h38);
    xf(1'b1, 8'h01, 8'h00);
    repeat (12) @(posedge pclk);
    src.level(1'b1);
    rd(8'h01, 32'h00);
    src.level(1'b0);
    rd(8'h01, 32'h01);
    xf(1'b1, 8'h85, 8'h00);
    xf(1'b1, 8'h05, 8'h1F);
    low4 <= 4'hA;
    @(posedge pclk);
    chk({27'h0, pa_out}, 32'h0F);
    chk({27'h0, pa_oe}, 32'h0F);
    rd(8'h05, 32'h0A);
    // soft reset keeps only the port change flag
    ext_set <= 1'b1;
    port_set <= 1'b1;
    @(posedge pclk);
    ext_set <= 1'b0;
    port_set <= 1'b0;
    soft_reset <= 1'b1;
    @(posedge pclk);
    soft_reset <= 1'b0;
    rd(8'h81, 32'hFF);
    rd(8'h0B, 32'h01);
    rd(8'h85, 32'h3F);
    // power-on reset in mid-run clears the port change flag too
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rd(8'h0B, 32'h00);
    rd(8'h81, 32'hFF);
    summarize();
  end
endmodule
`default_nettype wire
